// ---- jtag_tap_id_and_reset_tb.sv ----
module jtag_tap_id_and_reset_tb
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hwrite = 0, supply_good = 0, pll_lock = 0;
  logic boot_start, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, security_word = 32'h0;
  logic [31:0] hrdata, rv, junk;
  int miscompares = 0, comparisons = 0;

  always #50 hclk = ~hclk;

  tap_if link_if ();
  tap_host #(.settle_cycles(5)) tap_host_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .supply_good(supply_good), .link(link_if));
  tap_device tap_device_i (.link(link_if), .security_word(security_word),
    .pll_lock(pll_lock), .pin_in(8'h5a), .pin_out(), .pin_drive_test(),
    .boot_start(boot_start), .tile_tck(), .tile_tms(), .tile_tdi(), .tile_tdo(1'b0));
  tap_properties tap_properties_i (.tck(link_if.tck), .tms(link_if.tms),
    .tdi(link_if.tdi), .tdo(link_if.tdo), .tdo_oe(link_if.tdo_oe),
    .trst_n(link_if.trst_n));

  task automatic final_report;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  // Polling is bounded so a stuck engine ends the run instead of hanging it
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, reg_status, 32'h0, rv);
      n++;
    end while (rv[b] !== v && n < 300);
    if (n >= 300) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic run(input logic [31:0] c, input logic [31:0] d);
    xfer(1'b1, reg_wdata, d, junk);
    xfer(1'b1, reg_cmd, c, junk);
    poll(0, 1'b0);
    xfer(1'b0, reg_rdata, 32'h0, rv);
  endtask

  // Instruction load leaves the port in shift, so the second command exits it
  task automatic usercode(input logic [31:0] sw);
    security_word <= sw;
    xfer(1'b1, reg_ctrl, 32'h0, junk);
    @(posedge hclk);
    check(boot_start, 1'b0);
    check(link_if.trst_n, 1'b0);
    xfer(1'b1, reg_ctrl, 32'h3, junk);
    run(32'h0006, 32'h63);
    run(32'h3c0b, 32'h0);
    check(rv, {sw[31:22], 6'h0, die_revision_value});
    $display("test usercode done");
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, reg_ctrl, 32'h0, rv);
    check(rv, host_reset_value);
    xfer(1'b1, 32'h40, 32'hffffffff, junk);
    xfer(1'b0, 32'h40, 32'h0, rv);
    check(rv, 32'h0);
    xfer(1'b1, reg_ctrl, 32'h3, junk);
    repeat (20) @(posedge hclk);
    check(link_if.trst_n, 1'b0);
    $display("test reset hold done");
    supply_good <= 1'b1;
    xfer(1'b0, reg_status, 32'h0, rv);
    check(link_if.rst_n, 1'b0);
    poll(1, 1'b1);
    check(link_if.trst_n, 1'b1);
    check(boot_start, 1'b0);
    pll_lock <= 1'b1;
    run(32'h3802, 32'h0);
    check(rv, {id_version, id_part, id_mfr, 1'b1});
    check(boot_start, 1'b1);
    $display("test idcode done");
    usercode(32'h0);
    usercode(32'ha5400000);
    final_report();
  end

  initial begin
    repeat (90000) @(posedge hclk);
    miscompares++;
    final_report();
  end
endmodule

// ---- tap_device.sv ----
module tap_device
  import tap_pkg::*;
(
  tap_if.dut link,
  input wire logic [31:0] security_word,
  input wire logic pll_lock,
  input wire logic [tap_pkg::bscan_len-1:0] pin_in,
  output logic [tap_pkg::bscan_len-1:0] pin_out,
  output logic pin_drive_test,
  output logic boot_start,
  output logic tile_tck,
  output logic tile_tms,
  output logic tile_tdi,
  input wire logic tile_tdo
);
  import tap_pkg::*;

  tap_state_t state;
  tap_state_t next_state;
  logic [ir_width-1:0] ir_shift;
  logic [ir_width-1:0] ir;
  logic [dr_width-1:0] dr_shift;
  logic [bscan_len-1:0] bs_shift;
  logic bypass_bit;
  logic [31:0] id_word;
  logic [31:0] user_word;
  logic tdo_next;
  logic rst_sync1;
  logic rst_sync2;
  logic lock_sync1;
  logic lock_sync2;
  logic chip_tap;

  assign id_word = {id_version, id_part, id_mfr, 1'b1};
  // Unprogrammed fuses read as zero, so the tag comes out zero as well
  assign user_word = {security_word[31:uc_tag_lsb], 6'h0, die_revision_value};
  assign chip_tap = (ir == ins_chip);

  always_comb begin
    next_state = state;
    case (state)
      st_reset: next_state = link.tms ? st_reset : st_idle;
      st_idle: next_state = link.tms ? st_dr_sel : st_idle;
      st_dr_sel: next_state = link.tms ? st_ir_sel : st_dr_cap;
      st_dr_cap: next_state = link.tms ? st_dr_ex1 : st_dr_sh;
      st_dr_sh: next_state = link.tms ? st_dr_ex1 : st_dr_sh;
      st_dr_ex1: next_state = link.tms ? st_dr_up : st_dr_pa;
      st_dr_pa: next_state = link.tms ? st_dr_ex2 : st_dr_pa;
      st_dr_ex2: next_state = link.tms ? st_dr_up : st_dr_sh;
      st_dr_up: next_state = link.tms ? st_dr_sel : st_idle;
      st_ir_sel: next_state = link.tms ? st_reset : st_ir_cap;
      st_ir_cap: next_state = link.tms ? st_ir_ex1 : st_ir_sh;
      st_ir_sh: next_state = link.tms ? st_ir_ex1 : st_ir_sh;
      st_ir_ex1: next_state = link.tms ? st_ir_up : st_ir_pa;
      st_ir_pa: next_state = link.tms ? st_ir_ex2 : st_ir_pa;
      st_ir_ex2: next_state = link.tms ? st_ir_up : st_ir_sh;
      st_ir_up: next_state = link.tms ? st_dr_sel : st_idle;
      default: next_state = st_reset;
    endcase
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      state <= st_reset;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_shift <= '0;
      ir <= ins_idcode;
    end else begin
      if (state == st_ir_cap) begin
        ir_shift <= ir_capture;
      end else if (state == st_ir_sh) begin
        ir_shift <= {link.tdi, ir_shift[ir_width-1:1]};
      end
      if (state == st_reset) begin
        ir <= ins_idcode;
      end else if (state == st_ir_up) begin
        ir <= ir_shift;
      end
    end
  end

  // Data register capture and shift, LSB first toward the test output
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      dr_shift <= '0;
      bs_shift <= '0;
      bypass_bit <= 1'b0;
    end else if (state == st_dr_cap) begin
      bypass_bit <= 1'b0;
      bs_shift <= pin_in;
      case (ir)
        ins_idcode: dr_shift <= id_word;
        ins_usercode: dr_shift <= user_word;
        default: dr_shift <= '0;
      endcase
    end else if (state == st_dr_sh) begin
      bypass_bit <= link.tdi;
      bs_shift <= {link.tdi, bs_shift[bscan_len-1:1]};
      dr_shift <= {link.tdi, dr_shift[dr_width-1:1]};
    end
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      pin_out <= '0;
      pin_drive_test <= 1'b0;
    end else begin
      if (state == st_dr_up && (ir == ins_extest || ir == ins_sample)) begin
        pin_out <= bs_shift;
      end
      pin_drive_test <= (ir == ins_extest);
    end
  end

  always_comb begin
    tdo_next = bypass_bit;
    if (state == st_ir_sh) begin
      tdo_next = ir_shift[0];
    end else if (chip_tap) begin
      tdo_next = tile_tdo;
    end else begin
      case (ir)
        ins_idcode, ins_usercode: tdo_next = dr_shift[0];
        ins_extest, ins_sample: tdo_next = bs_shift[0];
        default: tdo_next = bypass_bit;
      endcase
    end
  end

  // Test output changes on the falling edge so the host samples it stable
  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      link.tdo <= 1'b0;
      link.tdo_oe <= 1'b0;
    end else begin
      link.tdo <= tdo_next;
      link.tdo_oe <= (state == st_ir_sh) || (state == st_dr_sh);
    end
  end

  // Inner tile TAP gets clock and mode select only while the chip instruction is held; data in always passes
  assign tile_tck = chip_tap ? link.tck : 1'b0;
  assign tile_tms = chip_tap ? link.tms : 1'b1;
  assign tile_tdi = link.tdi;

  always_ff @(posedge link.tck or negedge link.rst_n) begin
    if (!link.rst_n) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
      lock_sync1 <= 1'b0;
      lock_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
      lock_sync1 <= pll_lock;
      lock_sync2 <= lock_sync1;
    end
  end

  always_ff @(posedge link.tck or negedge link.rst_n) begin
    if (!link.rst_n) begin
      boot_start <= 1'b0;
    end else if (rst_sync2 && lock_sync2) begin
      boot_start <= 1'b1;
    end
  end
endmodule

// ---- tap_host.sv ----
module tap_host
  import tap_pkg::*;
#(
  parameter int settle_cycles = tap_pkg::settle_cycles_def
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic supply_good,
  tap_if.host link
);
  import tap_pkg::*;

  // Control bits: 0 test reset release, 1 chip reset release
  logic [1:0] ctrl;
  // Command: tms bits [7:0], clocks after the tms steps [13:9], start on write
  logic [13:0] cmd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic busy;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [5:0] bit_cnt;
  logic [1:0] div_cnt;
  logic [31:0] shift_out;
  logic [31:0] good_cnt;
  logic good_sync1;
  logic good_sync2;
  logic release_ok;
  logic tdo_s1;
  logic tdo_s2;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= host_reset_value;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= host_reset_value;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr)
        reg_ctrl: hrdata <= {30'h0, ctrl};
        reg_cmd: hrdata <= {18'h0, cmd};
        reg_wdata: hrdata <= wdata;
        reg_rdata: hrdata <= rdata;
        reg_status: hrdata <= {30'h0, release_ok, busy};
        default: hrdata <= host_reset_value;
      endcase
    end
  end

  // Supply good is a pin; resets stay low until it has settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_sync1 <= 1'b0;
      good_sync2 <= 1'b0;
      good_cnt <= '0;
    end else begin
      good_sync1 <= supply_good;
      good_sync2 <= good_sync1;
      if (!good_sync2) begin
        good_cnt <= '0;
      end else if (good_cnt < settle_cycles + treset_cycles) begin
        good_cnt <= good_cnt + 32'h1;
      end
    end
  end

  assign release_ok = (good_cnt >= settle_cycles + treset_cycles);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= 2'h0;
      cmd <= '0;
      wdata <= host_reset_value;
    end else if (wr_pend) begin
      case (wr_addr)
        reg_ctrl: ctrl <= hwdata[1:0];
        reg_cmd: cmd <= hwdata[13:0];
        reg_wdata: wdata <= hwdata;
        default: ;
      endcase
    end
  end

  assign link.trst_n = ctrl[0] && release_ok;
  assign link.rst_n = ctrl[1] && release_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo_s1 <= 1'b0;
      tdo_s2 <= 1'b0;
    end else begin
      tdo_s1 <= link.tdo;
      tdo_s2 <= tdo_s1;
    end
  end

  // Divided test clock: 8 TMS steps, then cmd[13:9] clocks with TMS low; wdata from bit 1 shifts out on tdi from the second clock on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      div_cnt <= '0;
      bit_cnt <= '0;
      link.tck <= 1'b0;
      link.tms <= 1'b1;
      link.tdi <= 1'b0;
      shift_out <= '0;
      rdata <= host_reset_value;
    end else if (!busy) begin
      link.tck <= 1'b0;
      if (wr_pend && wr_addr == reg_cmd) begin
        busy <= 1'b1;
        div_cnt <= '0;
        bit_cnt <= '0;
        shift_out <= wdata;
        link.tms <= hwdata[0];
      end
    end else begin
      div_cnt <= div_cnt + 2'h1;
      if (div_cnt == 2'h1) begin
        link.tck <= 1'b1;
      end else if (div_cnt == 2'h2) begin
        // Two synchroniser stages delay the output, so take it one host clock after the rise
        rdata <= {tdo_s2, rdata[31:1]};
      end else if (div_cnt == 2'h3) begin
        link.tck <= 1'b0;
        bit_cnt <= bit_cnt + 6'h1;
        shift_out <= {1'b0, shift_out[31:1]};
        link.tdi <= shift_out[1];
        if (bit_cnt >= {1'b0, cmd[13:9]} + 6'h7) begin
          busy <= 1'b0;
        end else begin
          link.tms <= (bit_cnt < 6'h7) ? cmd[bit_cnt[2:0] + 3'h1] : 1'b0;
        end
      end
    end
  end
endmodule

// ---- tap_if.sv ----
interface tap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic trst_n;
  logic rst_n;
  modport dut (input tck, input tms, input tdi, output tdo, output tdo_oe,
    input trst_n, input rst_n);
  modport host (output tck, output tms, output tdi, input tdo, input tdo_oe,
    output trst_n, output rst_n);
endinterface

// ---- tap_pkg.sv ----
package tap_pkg;
  localparam int ir_width = 4;
  localparam int dr_width = 32;
  // Instruction codes
  localparam logic [3:0] ins_extest = 4'h0;
  localparam logic [3:0] ins_sample = 4'h1;
  localparam logic [3:0] ins_idcode = 4'h2;
  localparam logic [3:0] ins_usercode = 4'h3;
  localparam logic [3:0] ins_chip = 4'h8;
  localparam logic [3:0] ins_bypass = 4'hf;
  localparam logic [3:0] ir_capture = 4'h1;
  // Identification word layout
  localparam int id_ver_lsb = 28;
  localparam int id_part_lsb = 12;
  localparam int id_mfr_lsb = 1;
  // Arbitrary identity values
  localparam logic [3:0] id_version = 4'h1;
  localparam logic [15:0] id_part = 16'h1234;
  localparam logic [10:0] id_mfr = 11'h2aa;
  // User code layout
  localparam int uc_tag_lsb = 22;
  localparam int uc_tag_width = 10;
  localparam logic [15:0] die_revision_value = 16'h0002;
  localparam logic [31:0] host_reset_value = 32'h0;
  localparam int bscan_len = 8;
  // Host register map
  localparam logic [31:0] reg_ctrl = 32'h0;
  localparam logic [31:0] reg_cmd = 32'h4;
  localparam logic [31:0] reg_wdata = 32'h8;
  localparam logic [31:0] reg_rdata = 32'hc;
  localparam logic [31:0] reg_status = 32'h10;
  localparam int clk_div = 4;
  // Release waits, in host clocks of 100 ns
  localparam int treset_ns = 100;
  localparam int treset_cycles = (treset_ns + 99) / 100;
  localparam int settle_us = 1000;
  localparam int settle_cycles_def = settle_us * 10;
  typedef enum logic [3:0] {
    st_reset = 4'h0, st_idle = 4'h1, st_dr_sel = 4'h2, st_dr_cap = 4'h3,
    st_dr_sh = 4'h4, st_dr_ex1 = 4'h5, st_dr_pa = 4'h6, st_dr_ex2 = 4'h7,
    st_dr_up = 4'h8, st_ir_sel = 4'h9, st_ir_cap = 4'ha, st_ir_sh = 4'hb,
    st_ir_ex1 = 4'hc, st_ir_pa = 4'hd, st_ir_ex2 = 4'he, st_ir_up = 4'hf
  } tap_state_t;
endpackage

// ---- tap_properties.sv ----
module tap_properties
  import tap_pkg::*;
(
  input logic tck,
  input logic tms,
  input logic tdi,
  input logic tdo,
  input logic tdo_oe,
  input logic trst_n
);
  localparam logic [31:0] id_word = {id_version, id_part, id_mfr, 1'b1};
  tap_state_t st;
  logic [3:0] ir;
  logic [3:0] ir_sr;
  logic [5:0] idx;

  function automatic tap_state_t nx(tap_state_t s, logic m);
    case (s)
      st_reset: return m ? st_reset : st_idle;
      st_idle, st_dr_up, st_ir_up: return m ? st_dr_sel : st_idle;
      st_dr_sel: return m ? st_ir_sel : st_dr_cap;
      st_dr_cap, st_dr_sh: return m ? st_dr_ex1 : st_dr_sh;
      st_dr_ex1: return m ? st_dr_up : st_dr_pa;
      st_dr_pa: return m ? st_dr_ex2 : st_dr_pa;
      st_dr_ex2: return m ? st_dr_up : st_dr_sh;
      st_ir_sel: return m ? st_reset : st_ir_cap;
      st_ir_cap, st_ir_sh: return m ? st_ir_ex1 : st_ir_sh;
      st_ir_ex1: return m ? st_ir_up : st_ir_pa;
      st_ir_pa: return m ? st_ir_ex2 : st_ir_pa;
      default: return m ? st_ir_up : st_ir_sh;
    endcase
  endfunction

  // Shadow of the port's state, built only from what travels on the wires
  always_ff @(posedge tck or negedge trst_n)
    st <= !trst_n ? st_reset : nx(st, tms);
  always_ff @(posedge tck or negedge trst_n)
    ir_sr <= !trst_n ? 4'h0 : (st == st_ir_sh ? {tdi, ir_sr[3:1]} : ir_sr);
  always_ff @(posedge tck or negedge trst_n)
    ir <= (!trst_n || st == st_reset) ? ins_idcode : (st == st_ir_up ? ir_sr : ir);
  always_ff @(posedge tck or negedge trst_n)
    idx <= (!trst_n || st == st_dr_cap) ? 6'h0 : idx + 6'(st == st_dr_sh);

  default clocking cb @(posedge tck);
  endclocking
  default disable iff (!trst_n);

  property p_oe_dr;
    st == st_dr_sh |-> tdo_oe;
  endproperty
  a_oe_dr: assert property (p_oe_dr)
    else $error("output not driven while shifting data");
  property p_oe_off;
    !(st == st_dr_sh || st == st_ir_sh) |-> !tdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven outside a shift");
  property p_ir_cap;
    st == st_ir_cap |=> (st != st_ir_sh || tdo) ##1 (st != st_ir_sh || !tdo);
  endproperty
  a_ir_cap: assert property (p_ir_cap)
    else $error("instruction capture pattern wrong");
  property p_id_bits;
    st == st_dr_sh && ir == ins_idcode && idx < 6'd32 |-> tdo == id_word[idx[4:0]];
  endproperty
  a_id_bits: assert property (p_id_bits)
    else $error("identification bit wrong");
  property p_id_lsb;
    st == st_dr_cap && ir == ins_idcode |=> st != st_dr_sh || $rose(tdo_oe) && tdo;
  endproperty
  a_id_lsb: assert property (p_id_lsb)
    else $error("identification word must start with one");
  property p_uc_rev;
    st == st_dr_sh && ir == ins_usercode && idx < 6'd16 |->
      tdo == die_revision_value[idx[3:0]];
  endproperty
  a_uc_rev: assert property (p_uc_rev)
    else $error("revision field bit wrong");
  property p_uc_zero;
    st == st_dr_sh && ir == ins_usercode && idx inside {[16:21]} |-> !tdo;
  endproperty
  a_uc_zero: assert property (p_uc_zero)
    else $error("unused user code bits not zero");
  property p_trst;
    $rose(trst_n) |-> !tdo_oe;
  endproperty
  a_trst: assert property (p_trst)
    else $error("output driven on leaving test reset");
endmodule
